// ---- verilog/scp_pkg.sv ----
// Behaviour
// - internal card clock divider divides master clock by value+1, then halves it.
// - external card clock divider divides master clock by value+1, then halves it.
// - both divider registers reset to ratio 13 before the final halving.
// - a new divider value loads only at a period end, so no glitch.
// - a divider value of zero behaves exactly like a value of one.
// - parity, break, retransmit and discard settings serve both card interfaces.
// - with parity checking on, every received character must have even parity.
// - in T=0 a failing character draws a break unless generation or checking is off.
// - in T=0 with detection on, a card break after our character is detected.
// - in T=0 with retransmit and detection on, a card break resends the character.
// - in T=0 with discard and checking on, a failing character is dropped.
// - the insert bit makes the transmitter send odd parity on every character.
// - the force bit flags a parity error on every received character.
// - a rejecting break starts 10.5 ETU after the received start bit edge.
// - the line is sampled for a card break 11 ETU after our start bit.
// - generated break lasts 1, 1.5 or 2 ETU by a 2-bit code; 11 reserved.
// - protocol select 0 means T=0, 1 means T=1; breaks only act in T=0.
`default_nettype none

package scp_pkg;

  // ----------------------------------------------------------------
  // register map (index, byte address is four times it)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned IDX_W  = 16;
  localparam logic [IDX_W-1:0] IDX_INT_DIV  = 16'hfe0f;
  localparam logic [IDX_W-1:0] IDX_EXT_DIV  = 16'hfe10;
  localparam logic [IDX_W-1:0] IDX_PAR_CTL  = 16'hfe11;
  localparam logic [IDX_W-1:0] IDX_CHAR_CTL = 16'hfe12;
  localparam logic [IDX_W-1:0] IDX_CTRL     = 16'hfe20;
  localparam logic [IDX_W-1:0] IDX_TXDATA   = 16'hfe21;
  localparam logic [IDX_W-1:0] IDX_RXDATA   = 16'hfe22;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 16'hfe23;
  localparam logic [IDX_W-1:0] IDX_MASK     = 16'hfe24;

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [5:0] DIV_RST      = 6'h0c;
  localparam logic [6:0] PAR_CTL_RST  = 7'h00;
  localparam logic [7:0] CHAR_CTL_RST = 8'h2c;
  localparam int unsigned PB_CHK_DIS   = 6;
  localparam int unsigned PB_GEN_DIS   = 5;
  localparam int unsigned PB_DET_DIS   = 4;
  localparam int unsigned PB_RETX      = 3;
  localparam int unsigned PB_DISCARD   = 2;
  localparam int unsigned PB_INS_PE    = 1;
  localparam int unsigned PB_FORCE_PE  = 0;
  localparam int unsigned CB_LEN_LO    = 3;
  localparam int unsigned CTL_PROTO    = 0;
  localparam int unsigned CTL_IFSEL    = 1;
  localparam int unsigned CTL_BUSY     = 7;
  localparam int unsigned ST_RX_DONE   = 0;
  localparam int unsigned ST_PAR_ERR   = 1;
  localparam int unsigned ST_BRK_DET   = 2;
  localparam int unsigned ST_TX_DONE   = 3;

  // ----------------------------------------------------------------
  // character timing in half-ETU steps
  // ----------------------------------------------------------------
  localparam logic [4:0] POS_EVAL    = 5'h14;
  localparam logic [4:0] POS_BRK_GEN = 5'h15;
  localparam logic [4:0] POS_BRK_SMP = 5'h16;
  localparam logic [4:0] BRK_LEN_1   = 5'h02;
  localparam logic [4:0] BRK_LEN_15  = 5'h03;
  localparam logic [4:0] BRK_LEN_2   = 5'h04;

  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX, ST_BRK} scp_state_t;

endpackage

`default_nettype wire

// ---- verilog/scp_ctrl.sv ----
`default_nettype none

module scp_ctrl
  import scp_pkg::*;
#(
  parameter int unsigned ETU_TICKS = 744
) (
  input  wire logic              CLOCK_IN,
  input  wire logic              NRST_IN,
  input  wire logic              PSEL_IN,
  input  wire logic              PENABLE_IN,
  input  wire logic              PWRITE_IN,
  input  wire logic [ADDR_W-1:0] PADDR_IN,
  input  wire logic [31:0]       PWDATA_IN,
  output logic      [31:0]       PRDATA_OUT,
  output logic                   PREADY_OUT,
  output logic                   PSLVERR_OUT,
  input  wire logic              IO_IN,
  output logic                   IO_OUT,
  output logic                   IO_OE_OUT,
  output logic                   CARD_CLK_INT_OUT,
  output logic                   CARD_CLK_EXT_OUT,
  output logic                   IRQ_OUT
);

  localparam logic [9:0] HALF_M1 = 10'(ETU_TICKS / 2 - 1);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [5:0]       div_q [2];
  logic [5:0]       lim_q [2];
  logic [5:0]       cnt_q [2];
  logic [1:0]       tick;
  logic [1:0]       cclk_q;
  logic [6:0]       par_q;
  logic [7:0]       char_q;
  logic [1:0]       ctrl_q;
  logic [7:0]       txdata_q;
  logic [7:0]       rxdata_q;
  logic [3:0]       stat_q;
  logic [3:0]       mask_q;
  logic             irq_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;
  logic [31:0]      rd_data;
  logic             rd_hit;
  logic             acc;
  logic             wr;
  logic [IDX_W-1:0] idx;
  logic             io_s1_q;
  logic             io_s2_q;
  logic             io_s3_q;
  logic             io_fall;
  scp_state_t       state_q;
  logic [9:0]       etu_cnt_q;
  logic             act_tick;
  logic             half_p;
  logic [4:0]       hpos_q;
  logic [9:0]       tx_sh_q;
  logic [9:0]       rx_sh_q;
  logic             io_oe_q;
  logic             tx_pend_q;
  logic             err_q;
  logic             rx_err;
  logic             rx_drop;
  logic             t0;
  logic [4:0]       brk_len;
  logic [3:0]       ev;
  logic             ev_rx_q;
  logic             ev_perr_q;
  logic             ev_brk_q;
  logic             ev_txd_q;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign acc = PSEL_IN & PENABLE_IN;
  assign idx = PADDR_IN[ADDR_W-1:2];
  assign wr  = acc & pready_q & PWRITE_IN;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (idx)
      IDX_INT_DIV:  rd_data[5:0] = div_q[0];
      IDX_EXT_DIV:  rd_data[5:0] = div_q[1];
      IDX_PAR_CTL:  rd_data[6:0] = par_q;
      IDX_CHAR_CTL: rd_data[7:0] = char_q;
      IDX_CTRL: begin
        rd_data[1:0]     = ctrl_q;
        rd_data[CTL_BUSY] = (state_q != ST_IDLE) | tx_pend_q;
      end
      IDX_TXDATA:   rd_data[7:0] = txdata_q;
      IDX_RXDATA:   rd_data[7:0] = rxdata_q;
      IDX_STATUS:   rd_data[3:0] = stat_q;
      IDX_MASK:     rd_data[3:0] = mask_q;
      default:      rd_hit = 1'b0;
    endcase
  end

  // answer one cycle into the access phase
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~rd_hit;
      if (acc & ~pready_q) begin
        prdata_q <= rd_data;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      div_q[0] <= DIV_RST;
      div_q[1] <= DIV_RST;
      par_q    <= PAR_CTL_RST;
      char_q   <= CHAR_CTL_RST;
      ctrl_q   <= 2'h0;
      txdata_q <= 8'h00;
      mask_q   <= 4'h0;
    end else if (wr) begin
      case (idx)
        IDX_INT_DIV:  div_q[0] <= PWDATA_IN[5:0];
        IDX_EXT_DIV:  div_q[1] <= PWDATA_IN[5:0];
        IDX_PAR_CTL:  par_q    <= PWDATA_IN[6:0];
        IDX_CHAR_CTL: char_q   <= PWDATA_IN[7:0];
        IDX_CTRL:     ctrl_q   <= PWDATA_IN[1:0];
        IDX_TXDATA:   txdata_q <= PWDATA_IN[7:0];
        IDX_MASK:     mask_q   <= PWDATA_IN[3:0];
        default:      ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sticky status and interrupt
  // ----------------------------------------------------------------
  assign ev = {ev_txd_q, ev_brk_q, ev_perr_q, ev_rx_q};

  // a new event wins over a clear in the same cycle
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      stat_q <= 4'h0;
    end else begin
      stat_q <= (stat_q & ~((wr && idx == IDX_STATUS) ? PWDATA_IN[3:0] : 4'h0)) | ev;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // card clock dividers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_div
    assign tick[g] = (cnt_q[g] == lim_q[g]);
    always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
        cnt_q[g]  <= 6'h00;
        lim_q[g]  <= DIV_RST;
        cclk_q[g] <= 1'b0;
      end else if (tick[g]) begin
        cnt_q[g]  <= 6'h00;
        lim_q[g]  <= (div_q[g] == 6'h00) ? 6'h01 : div_q[g];
        cclk_q[g] <= ~cclk_q[g];
      end else begin
        cnt_q[g] <= cnt_q[g] + 6'h01;
      end
    end
  end

  a_int_clk_edge : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (cclk_q[0] != $past(cclk_q[0])) |-> $past(cnt_q[0]) == $past(lim_q[0]))
    else $error("internal card clock moved off a divider period end");

  a_ext_clk_edge : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    tick[1] |=> (cclk_q[1] != $past(cclk_q[1])) && cnt_q[1] == 6'h00)
    else $error("external card clock did not toggle at period end");

  a_div_load : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    !tick[0] |=> $stable(lim_q[0]))
    else $error("divider limit changed inside a period");

  a_div_zero : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (tick[1] && div_q[1] == 6'h00) |=> lim_q[1] == 6'h01)
    else $error("zero divider value not treated as one");

  // ----------------------------------------------------------------
  // line synchroniser and etu timing
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      io_s1_q <= 1'b1;
      io_s2_q <= 1'b1;
      io_s3_q <= 1'b1;
    end else begin
      io_s1_q <= IO_IN;
      io_s2_q <= io_s1_q;
      io_s3_q <= io_s2_q;
    end
  end

  assign io_fall  = io_s3_q & ~io_s2_q;
  assign act_tick = tick[ctrl_q[CTL_IFSEL]];
  assign half_p   = act_tick && (etu_cnt_q == HALF_M1);
  assign t0       = ~ctrl_q[CTL_PROTO];

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      etu_cnt_q <= 10'h000;
    end else if (state_q == ST_IDLE) begin
      etu_cnt_q <= 10'h000;
    end else if (act_tick) begin
      etu_cnt_q <= half_p ? 10'h000 : etu_cnt_q + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // character checks
  // ----------------------------------------------------------------
  assign rx_err  = (~par_q[PB_CHK_DIS] & (^rx_sh_q[9:1])) | par_q[PB_FORCE_PE];
  assign rx_drop = rx_err & t0 & par_q[PB_DISCARD] & ~par_q[PB_CHK_DIS];

  always_comb begin
    case (char_q[CB_LEN_LO+1:CB_LEN_LO])
      2'b01:   brk_len = BRK_LEN_15;
      2'b10:   brk_len = BRK_LEN_2;
      default: brk_len = BRK_LEN_1;
    endcase
  end

  // ----------------------------------------------------------------
  // character sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q   <= ST_IDLE;
      hpos_q    <= 5'h00;
      tx_sh_q   <= 10'h3ff;
      rx_sh_q   <= 10'h000;
      io_oe_q   <= 1'b0;
      tx_pend_q <= 1'b0;
      err_q     <= 1'b0;
      rxdata_q  <= 8'h00;
      ev_rx_q   <= 1'b0;
      ev_perr_q <= 1'b0;
      ev_brk_q  <= 1'b0;
      ev_txd_q  <= 1'b0;
    end else begin
      ev_rx_q   <= 1'b0;
      ev_perr_q <= 1'b0;
      ev_brk_q  <= 1'b0;
      ev_txd_q  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          io_oe_q <= 1'b0;
          hpos_q  <= 5'h00;
          if (io_fall) begin
            state_q <= ST_RX;
          end else if (tx_pend_q && io_s2_q) begin
            tx_pend_q <= 1'b0;
            tx_sh_q   <= {^txdata_q ^ par_q[PB_INS_PE], txdata_q, 1'b0};
            state_q   <= ST_TX;
          end
        end
        ST_TX: begin
          io_oe_q <= ~tx_sh_q[0];
          if (half_p) begin
            hpos_q <= hpos_q + 5'h01;
            if (hpos_q[0]) begin
              tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            end
            if (hpos_q == POS_BRK_SMP - 5'h01) begin
              state_q <= ST_IDLE;
              if (t0 && !par_q[PB_DET_DIS] && !io_s2_q) begin
                ev_brk_q <= 1'b1;
                if (par_q[PB_RETX]) begin
                  tx_pend_q <= 1'b1;
                end
              end else begin
                ev_txd_q <= 1'b1;
              end
            end
          end
        end
        ST_RX: begin
          if (half_p) begin
            hpos_q <= hpos_q + 5'h01;
            if (!hpos_q[0] && hpos_q < POS_EVAL) begin
              rx_sh_q <= {io_s2_q, rx_sh_q[9:1]};
            end
            if (hpos_q == POS_EVAL - 5'h01) begin
              err_q     <= rx_err;
              ev_perr_q <= rx_err;
              if (!rx_drop) begin
                rxdata_q <= rx_sh_q[8:1];
                ev_rx_q  <= 1'b1;
              end
            end
            if (hpos_q == POS_BRK_GEN - 5'h01) begin
              if (err_q && t0 && !par_q[PB_GEN_DIS] && !par_q[PB_CHK_DIS]) begin
                io_oe_q <= 1'b1;
                state_q <= ST_BRK;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
        end
        ST_BRK: begin
          if (half_p) begin
            hpos_q <= hpos_q + 5'h01;
            if (hpos_q == POS_BRK_GEN + brk_len - 5'h01) begin
              io_oe_q <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (PWRITE_IN && acc && pready_q && idx == IDX_TXDATA) begin
        tx_pend_q <= 1'b1;
      end
    end
  end

  a_break_cause : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_BRK && $past(state_q) == ST_RX)
    |-> $past(err_q) && t0 && !par_q[PB_GEN_DIS] && !par_q[PB_CHK_DIS])
    else $error("break generated without a permitted parity failure");

  a_break_start : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (io_oe_q && state_q == ST_BRK && $past(state_q) == ST_RX) |-> hpos_q == POS_BRK_GEN)
    else $error("break did not start at 10.5 ETU");

  a_brk_sample : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    ev_brk_q |-> $past(state_q) == ST_TX && hpos_q == POS_BRK_SMP && t0)
    else $error("card break flagged away from the 11 ETU sample");

  a_retx_queue : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (ev_brk_q && par_q[PB_RETX]) |-> tx_pend_q)
    else $error("card break did not queue a resend");

  a_discard : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    ev_rx_q |-> !($past(rx_drop)))
    else $error("failing character kept despite discard");

  a_force_err : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_RX && half_p && hpos_q == POS_EVAL - 5'h01 && par_q[PB_FORCE_PE])
    |=> ev_perr_q)
    else $error("forced parity error not flagged");

  a_tx_parity : assert property (
    @(posedge CLOCK_IN) disable iff (!NRST_IN)
    (state_q == ST_TX && $past(state_q) == ST_IDLE)
    |-> (^tx_sh_q[9:1]) == $past(par_q[PB_INS_PE]))
    else $error("transmitted parity does not match insert setting");

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA_OUT       = prdata_q;
  assign PREADY_OUT       = pready_q;
  assign PSLVERR_OUT      = pslverr_q;
  assign IO_OUT           = 1'b0;
  assign IO_OE_OUT        = io_oe_q;
  assign CARD_CLK_INT_OUT = cclk_q[0];
  assign CARD_CLK_EXT_OUT = cclk_q[1];
  assign IRQ_OUT          = irq_q;

endmodule

`default_nettype wire

// ---- testbench/scp_card.sv ----
`default_nettype none

module scp_card
#(
  parameter int ETU = 16
) (
  input  wire logic clk_in,
  input  wire logic io_in,
  output logic      pull_low_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pull_low_out = 1'b0;

  // ----------------------------------------------------------------
  // card transmits: start, 8 data lsb first, parity; then watch for break
  // ----------------------------------------------------------------
  task automatic send_char(input logic [7:0] d, input bit bad,
                           output int brk_at, output int brk_len);
    logic [9:0] bits;
    bits    = {^d ^ bad, d, 1'b0};
    brk_at  = 0;
    brk_len = 0;
    for (int i = 0; i < 10 * ETU; i++) begin
      @(posedge clk_in);
      pull_low_out <= ~bits[i / ETU];
    end
    for (int i = 10 * ETU; i < 14 * ETU; i++) begin
      @(posedge clk_in);
      if (i == 10 * ETU) begin
        pull_low_out <= 1'b0;
      end else if (!io_in) begin
        if (brk_len == 0) brk_at = i;
        brk_len++;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // card receives at mid-bit; optional break held across 11 ETU
  // ----------------------------------------------------------------
  task automatic recv_char(input bit brk, output logic [8:0] got, output bit ok);
    int n;
    ok  = 1'b0;
    got = '0;
    for (n = 0; n < 2000 && io_in; n++) @(posedge clk_in);
    if (!io_in) begin
      ok = 1'b1;
      repeat (ETU / 2) @(posedge clk_in);
      for (int i = 0; i < 9; i++) begin
        repeat (ETU) @(posedge clk_in);
        got[i] = io_in;
      end
      repeat (ETU) @(posedge clk_in);
      pull_low_out <= brk;
      repeat (2 * ETU) @(posedge clk_in);
      pull_low_out <= 1'b0;
      // a resend may start as soon as the line is back high
      repeat (2) @(posedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

// ---- testbench/smart_card_clock_parity_ctrl_bench.sv ----
`default_nettype none

module smart_card_clock_parity_ctrl_bench import scp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int ETU = 16;
  logic              clk, nrst, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic              pready, pslverr, io_oe, clk_int, clk_ext, irq, card_low, line, rerr, io_o;
  int                errors, checks, p;
  logic [8:0]        got;
  bit                ok;

  assign line = ~(io_oe | card_low);

  scp_ctrl #(
    .ETU_TICKS (8)
  ) u_scp_ctrl (
    .CLOCK_IN         (clk),
    .NRST_IN          (nrst),
    .PSEL_IN          (psel),
    .PENABLE_IN       (penable),
    .PWRITE_IN        (pwrite),
    .PADDR_IN         (paddr),
    .PWDATA_IN        (pwdata),
    .PRDATA_OUT       (prdata),
    .PREADY_OUT       (pready),
    .PSLVERR_OUT      (pslverr),
    .IO_IN            (line),
    .IO_OUT           (io_o),
    .IO_OE_OUT        (io_oe),
    .CARD_CLK_INT_OUT (clk_int),
    .CARD_CLK_EXT_OUT (clk_ext),
    .IRQ_OUT          (irq)
  );

  scp_card #(
    .ETU (ETU)
  ) u_scp_card (
    .clk_in       (clk),
    .io_in        (line),
    .pull_low_out (card_low)
  );

  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input bit wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      complete_run();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle cycle, so back-to-back calls never drive psel twice in a step
    @(posedge clk);
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic period(input bit ext, output int per);
    int r1;
    logic prev, cur;
    r1 = -1;
    per = -1;
    prev = 1'b1;
    for (int n = 0; n < 400 && per < 0; n++) begin
      @(posedge clk);
      cur = ext ? clk_ext : clk_int;
      if (cur && !prev) begin
        if (r1 < 0) r1 = n;
        else per = n - r1;
      end
      prev = cur;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic rx_case(input logic [1:0] ctl, input logic [6:0] pctl, input logic [7:0] cctl,
                         input logic [7:0] d, input bit bad, input int len_exp,
                         input bit pe_exp, input logic [7:0] rx_exp);
    int at, len;
    wr(IDX_CTRL, {30'h0, ctl});
    wr(IDX_PAR_CTL, {25'h0, pctl});
    wr(IDX_CHAR_CTL, {24'h0, cctl});
    wr(IDX_STATUS, 32'hf);
    u_scp_card.send_char(d, bad, at, len);
    chk("break length", len, len_exp);
    if (len_exp > 0) chk("break start", (at >= 21 * ETU / 2 && at <= 11 * ETU), 1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("parity error flag", rdat[ST_PAR_ERR], pe_exp);
    apb(1'b0, IDX_RXDATA, 32'h0);
    chk("received data", rdat[7:0], rx_exp);
  endtask

  task automatic tx_case(input logic [6:0] pctl, input bit brk, input logic [7:0] d,
                         input bit resend_exp);
    wr(IDX_PAR_CTL, {25'h0, pctl});
    wr(IDX_STATUS, 32'hf);
    fork
      wr(IDX_TXDATA, {24'h0, d});
      u_scp_card.recv_char(brk, got, ok);
    join
    chk("sent char", got, {^d ^ pctl[PB_INS_PE], d});
    u_scp_card.recv_char(1'b0, got, ok);
    chk("resend seen", ok, resend_exp);
    if (resend_exp) chk("resent char", got, {^d, d});
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("card break flag", rdat[ST_BRK_DET], brk && !pctl[PB_DET_DIS]);
  endtask

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, IDX_INT_DIV, 32'h0);
    chk("int div reset", rdat, 32'h0c);
    apb(1'b0, IDX_EXT_DIV, 32'h0);
    chk("ext div reset", rdat, 32'h0c);
    apb(1'b0, IDX_PAR_CTL, 32'h0);
    chk("parity ctl reset", rdat, 32'h00);
    apb(1'b0, IDX_CHAR_CTL, 32'h0);
    chk("char ctl reset", rdat, 32'h2c);
    apb(1'b0, 16'h0000, 32'h0);
    chk("unmapped error", rerr, 1'b1);
    chk("io drive level", io_o, 1'b0);
    period(1'b0, p);
    chk("int clock reset period", p, 26);
    wr(IDX_INT_DIV, 32'h0);
    wr(IDX_EXT_DIV, 32'h0);
    period(1'b0, p);
    period(1'b0, p);
    chk("int clock value zero", p, 4);
    period(1'b1, p);
    chk("ext clock value zero", p, 4);
    wr(IDX_EXT_DIV, 32'h5);
    period(1'b1, p);
    period(1'b1, p);
    chk("ext clock period", p, 12);
    wr(IDX_INT_DIV, 32'h1);
    wr(IDX_EXT_DIV, 32'h1);
    rx_case(2'h0, 7'h00, 8'h00, 8'ha5, 1'b0, 0, 1'b0, 8'ha5);
    rx_case(2'h0, 7'h00, 8'h00, 8'h3c, 1'b1, ETU, 1'b1, 8'h3c);
    rx_case(2'h0, 7'h00, 8'h08, 8'h3c, 1'b1, 3 * ETU / 2, 1'b1, 8'h3c);
    rx_case(2'h0, 7'h00, 8'h10, 8'h3c, 1'b1, 2 * ETU, 1'b1, 8'h3c);
    rx_case(2'h0, 7'h00, 8'h18, 8'h3c, 1'b1, ETU, 1'b1, 8'h3c);
    rx_case(2'h0, 7'h04, 8'h00, 8'hc3, 1'b1, ETU, 1'b1, 8'h3c);
    rx_case(2'h0, 7'h40, 8'h00, 8'hc3, 1'b1, 0, 1'b0, 8'hc3);
    rx_case(2'h0, 7'h20, 8'h00, 8'h5a, 1'b1, 0, 1'b1, 8'h5a);
    rx_case(2'h0, 7'h01, 8'h00, 8'h11, 1'b0, ETU, 1'b1, 8'h11);
    rx_case(2'h1, 7'h00, 8'h00, 8'h22, 1'b1, 0, 1'b1, 8'h22);
    rx_case(2'h2, 7'h00, 8'h00, 8'h33, 1'b1, ETU, 1'b1, 8'h33);
    wr(IDX_CTRL, 32'h0);
    tx_case(7'h00, 1'b0, 8'h96, 1'b0);
    tx_case(7'h02, 1'b0, 8'h96, 1'b0);
    tx_case(7'h18, 1'b1, 8'h4b, 1'b0);
    tx_case(7'h08, 1'b1, 8'h4b, 1'b1);
    chk("irq while masked", irq, 1'b0);
    wr(IDX_MASK, 32'h1 << ST_BRK_DET);
    repeat (2) @(posedge clk);
    chk("irq unmasked", irq, 1'b1);
    wr(IDX_STATUS, 32'h1 << ST_BRK_DET);
    repeat (2) @(posedge clk);
    chk("irq after clear", irq, 1'b0);
    complete_run();
  end
endmodule

`default_nettype wire
